// *** core/pwcd_pkg.sv ***
// Constants shared by both ends of the pulse-timed single control wire.
// Assumes one 100 MHz clock on each end and a wire driven by the host only.
package pwcd_pkg;

  // ==========================================================================
  // Clock and widths
  // ==========================================================================
  localparam int CLK_NS = 10;
  localparam int RUN_W  = 21;
  localparam int VAL_W  = 8;

  function automatic longint cyc_up(input longint ns);
    cyc_up = (ns + CLK_NS - 1) / CLK_NS;
    if (cyc_up < 1) cyc_up = 1;
  endfunction

  function automatic longint cyc_dn(input longint ns);
    cyc_dn = ns / CLK_NS;
    if (cyc_dn < 1) cyc_dn = 1;
  endfunction

  // ==========================================================================
  // Wire timing, each figure in its own unit
  // ==========================================================================
  localparam longint WAKE_HIGH_MS      = 1;
  localparam longint PULSE_MIN_NS      = 750;
  localparam longint PULSE_MAX_US      = 250;
  localparam longint LATCH_HOLD_MIN_US = 550;
  localparam longint ADDR_HOLD_MAX_US  = 5000;
  localparam longint STANDBY_HIGH_MS   = 10;
  localparam longint BUS_RESET_MS      = 12;
  localparam longint SHUTDOWN_LOW_MS   = 10;

  localparam logic [RUN_W-1:0] WAKE_CYC = RUN_W'(cyc_up(WAKE_HIGH_MS * 1000000));
  localparam logic [RUN_W-1:0] PULSE_MIN_CYC = RUN_W'(cyc_up(PULSE_MIN_NS));
  localparam logic [RUN_W-1:0] PULSE_MAX_CYC = RUN_W'(cyc_dn(PULSE_MAX_US * 1000));
  localparam logic [RUN_W-1:0] HOLD_CYC = RUN_W'(cyc_up(LATCH_HOLD_MIN_US * 1000));
  localparam logic [RUN_W-1:0] ADDR_HOLD_MAX_CYC = RUN_W'(cyc_dn(ADDR_HOLD_MAX_US * 1000));
  localparam logic [RUN_W-1:0] STANDBY_CYC = RUN_W'(cyc_dn(STANDBY_HIGH_MS * 1000000));
  localparam logic [RUN_W-1:0] BUS_RESET_CYC = RUN_W'(cyc_up(BUS_RESET_MS * 1000000));
  localparam logic [RUN_W-1:0] SHUTDOWN_CYC = RUN_W'(cyc_up(SHUTDOWN_LOW_MS * 1000000));

  // Host pulse and gap width: twice the least width, well under the most.
  localparam logic [RUN_W-1:0] HOST_PULSE_CYC = RUN_W'(2 * PULSE_MIN_CYC);

endpackage

// *** core/pwcd_if.sv ***
// The single control wire between host and device.
// Assumes the host alone drives it; the device only listens.
interface pwcd_if;
  logic single_wire_control_pin;

  modport host_end(output single_wire_control_pin);
  modport device_end(input single_wire_control_pin);
endinterface

// *** core/pwcd_device.sv ***
// Device end: decodes wake, pulse groups, latches, bus reset and shutdown.
// Assumes the wire is asynchronous to clk and the host keeps its timing.
module pwcd_device #(
  parameter int                       VAL_W    = pwcd_pkg::VAL_W,
  parameter logic [pwcd_pkg::RUN_W-1:0] WAKE    = pwcd_pkg::WAKE_CYC,
  parameter logic [pwcd_pkg::RUN_W-1:0] HOLD    = pwcd_pkg::HOLD_CYC,
  parameter logic [pwcd_pkg::RUN_W-1:0] STANDBY = pwcd_pkg::STANDBY_CYC,
  parameter logic [pwcd_pkg::RUN_W-1:0] BUS_RST = pwcd_pkg::BUS_RESET_CYC,
  parameter logic [pwcd_pkg::RUN_W-1:0] SHUTDN  = pwcd_pkg::SHUTDOWN_CYC
) (
  input  wire logic             clk,
  input  wire logic             reset,
  pwcd_if.device_end            link,
  input  wire logic             sinks_off,
  output logic                  enabled,
  output logic                  sleep,
  output logic                  addr_valid,
  output logic                  wr_valid,
  output logic [VAL_W-1:0]      wr_addr,
  output logic [VAL_W-1:0]      wr_data,
  output logic                  bus_reset_pulse,
  output logic                  standby
);

  localparam int RW = pwcd_pkg::RUN_W;

  typedef enum logic [1:0] {
    PWCD_OFF,
    PWCD_ADDR,
    PWCD_DATA
  } pwcd_state_e;

  function automatic logic [VAL_W-1:0] cnt_to_val(input logic [VAL_W:0] c);
    logic [VAL_W:0] v;
    v = c - 1'b1;
    cnt_to_val = v[VAL_W-1:0];
  endfunction

  // ==========================================================================
  // Wire synchroniser and run-length counter
  // ==========================================================================
  logic          sync1_r;
  logic          sync2_r;
  logic          prev_r;
  logic [RW-1:0] run_r;
  logic [RW-1:0] run_nxt;

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= link.single_wire_control_pin;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  wire level  = sync2_r;
  wire toggle = sync2_r ^ prev_r;
  wire rise   = sync2_r & ~prev_r;
  wire run_at_max = &run_r;

  // The run counter restarts on every edge and saturates, so a hold
  // of any length is seen once at each threshold.
  assign run_nxt = toggle ? '0 : (run_at_max ? run_r : run_r + 1'b1);

  always_ff @(posedge clk) begin
    if (reset) begin
      run_r <= '0;
    end else begin
      run_r <= run_nxt;
    end
  end

  // ==========================================================================
  // Timing events
  // ==========================================================================
  wire high_run = level & ~toggle;
  wire low_run  = ~level & ~toggle;

  wire wake_hit  = high_run & (run_r == WAKE - 1'b1);
  wire shut_hit  = low_run & (run_r == SHUTDN - 1'b1);
  // latch hold
  // The edge cycle and the run count from zero make two high cycles.
  // So run_r equal to HOLD-2 marks exactly HOLD cycles of high level.
  wire hold_hit  = high_run & (run_r == HOLD - 2'h2);
  wire stby_hit  = high_run & (run_r == STANDBY);
  wire brst_hit  = high_run & (run_r == BUS_RST - 1'b1);

  // ==========================================================================
  // Decoder state
  // ==========================================================================
  pwcd_state_e      state_r;
  pwcd_state_e      state_nxt;
  logic [VAL_W:0]   cnt_r;
  logic [VAL_W:0]   cnt_nxt;
  logic [VAL_W-1:0] addr_r;
  logic [VAL_W-1:0] addr_nxt;
  logic [VAL_W-1:0] data_r;
  logic [VAL_W-1:0] data_nxt;
  logic             wr_nxt;
  logic             adv_nxt;
  logic             brst_nxt;
  logic             stby_r;
  logic             stby_nxt;

  wire group_seen = |cnt_r;
  wire cnt_full   = &cnt_r;
  wire active     = (state_r != PWCD_OFF);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    addr_nxt  = addr_r;
    data_nxt  = data_r;
    wr_nxt    = 1'b0;
    adv_nxt   = 1'b0;
    brst_nxt  = 1'b0;
    stby_nxt  = stby_r;
    case (state_r)
      PWCD_OFF: begin
        cnt_nxt = '0;
        if (wake_hit) begin
          state_nxt = PWCD_ADDR;
          stby_nxt  = 1'b1;
        end
      end
      PWCD_ADDR, PWCD_DATA: begin
        if (rise) begin
          stby_nxt = 1'b0;
          if (!cnt_full) begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
        if (hold_hit && group_seen) begin
          cnt_nxt = '0;
          if (state_r == PWCD_ADDR) begin
            addr_nxt  = cnt_to_val(cnt_r);
            adv_nxt   = 1'b1;
            state_nxt = PWCD_DATA;
          end else begin
            data_nxt  = cnt_to_val(cnt_r);
            wr_nxt    = 1'b1;
            state_nxt = PWCD_ADDR;
          end
        end
        if (stby_hit) begin
          cnt_nxt   = '0;
          state_nxt = PWCD_ADDR;
          stby_nxt  = 1'b1;
        end
        if (brst_hit) begin
          cnt_nxt   = '0;
          addr_nxt  = '0;
          state_nxt = PWCD_ADDR;
          brst_nxt  = 1'b1;
          stby_nxt  = 1'b1;
        end
        if (shut_hit) begin
          cnt_nxt   = '0;
          state_nxt = PWCD_OFF;
          stby_nxt  = 1'b0;
        end
      end
      default: begin
        state_nxt = PWCD_OFF;
        cnt_nxt   = '0;
        stby_nxt  = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Registers and outputs
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= PWCD_OFF;
      cnt_r   <= '0;
      addr_r  <= '0;
      data_r  <= '0;
      stby_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      addr_r  <= addr_nxt;
      data_r  <= data_nxt;
      stby_r  <= stby_nxt;
    end
  end

  logic en_r;
  logic sleep_r;
  logic wr_r;
  logic adv_r;
  logic brst_r;

  wire en_nxt = (state_nxt != PWCD_OFF);
  wire sleep_nxt = en_nxt & sinks_off;

  always_ff @(posedge clk) begin
    if (reset) begin
      en_r    <= 1'b0;
      sleep_r <= 1'b0;
      wr_r    <= 1'b0;
      adv_r   <= 1'b0;
      brst_r  <= 1'b0;
    end else begin
      en_r    <= en_nxt;
      sleep_r <= sleep_nxt;
      wr_r    <= wr_nxt;
      adv_r   <= adv_nxt;
      brst_r  <= brst_nxt & active;
    end
  end

  assign enabled         = en_r;
  assign sleep           = sleep_r;
  assign wr_valid        = wr_r;
  assign addr_valid      = adv_r;
  assign wr_addr         = addr_r;
  assign wr_data         = data_r;
  assign bus_reset_pulse = brst_r;
  assign standby         = stby_r;

endmodule

// *** core/pwcd_host.sv ***
// Host end: drives wake, address and data pulse groups, and shutdown.
// Assumes a value v is sent as v+1 pulses, so a group is never empty.
module pwcd_host #(
  parameter int                         VAL_W = pwcd_pkg::VAL_W,
  parameter logic [pwcd_pkg::RUN_W-1:0] WAKE  = pwcd_pkg::WAKE_CYC,
  parameter logic [pwcd_pkg::RUN_W-1:0] PULSE = pwcd_pkg::HOST_PULSE_CYC,
  parameter logic [pwcd_pkg::RUN_W-1:0] HOLD  = pwcd_pkg::HOLD_CYC,
  parameter logic [pwcd_pkg::RUN_W-1:0] SHUTDN = pwcd_pkg::SHUTDOWN_CYC
) (
  input  wire logic             clk,
  input  wire logic             reset,
  pwcd_if.host_end              link,
  input  wire logic             wake_req,
  input  wire logic             shut_req,
  input  wire logic             cmd_valid,
  input  wire logic [VAL_W-1:0] cmd_addr,
  input  wire logic [VAL_W-1:0] cmd_data,
  output logic                  cmd_ready,
  output logic                  dev_on
);

  localparam int RW = pwcd_pkg::RUN_W;

  typedef enum logic [2:0] {
    PWCD_H_OFF,
    PWCD_H_WAKE,
    PWCD_H_IDLE,
    PWCD_H_GAP,
    PWCD_H_PULSE,
    PWCD_H_HOLD,
    PWCD_H_SHUT
  } pwcd_hstate_e;

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  pwcd_hstate_e     st_r;
  pwcd_hstate_e     st_nxt;
  logic [RW-1:0]    tmr_r;
  logic [RW-1:0]    tmr_nxt;
  logic [VAL_W:0]   left_r;
  logic [VAL_W:0]   left_nxt;
  logic [VAL_W-1:0] data_r;
  logic [VAL_W-1:0] data_nxt;
  logic             phase_r;
  logic             phase_nxt;
  logic             wire_r;
  logic             wire_nxt;
  logic             on_r;
  logic             on_nxt;
  logic             rdy_r;

  wire tmr_done  = (tmr_r == '0);
  wire last_one  = (left_r == {{VAL_W{1'b0}}, 1'b1});
  wire cmd_take  = cmd_valid & rdy_r;

  always_comb begin
    st_nxt    = st_r;
    tmr_nxt   = tmr_done ? tmr_r : tmr_r - 1'b1;
    left_nxt  = left_r;
    data_nxt  = data_r;
    phase_nxt = phase_r;
    wire_nxt  = wire_r;
    on_nxt    = on_r;
    case (st_r)
      PWCD_H_OFF: begin
        wire_nxt = 1'b0;
        if (wake_req) begin
          st_nxt   = PWCD_H_WAKE;
          wire_nxt = 1'b1;
          tmr_nxt  = WAKE - 1'b1;
        end
      end
      PWCD_H_WAKE: begin
        if (tmr_done) begin
          st_nxt = PWCD_H_IDLE;
          on_nxt = 1'b1;
        end
      end
      PWCD_H_IDLE: begin
        wire_nxt = 1'b1;
        if (shut_req) begin
          st_nxt   = PWCD_H_SHUT;
          wire_nxt = 1'b0;
          tmr_nxt  = SHUTDN - 1'b1;
        end else if (cmd_take) begin
          st_nxt    = PWCD_H_GAP;
          wire_nxt  = 1'b0;
          tmr_nxt   = PULSE - 1'b1;
          left_nxt  = {1'b0, cmd_addr} + 1'b1;
          data_nxt  = cmd_data;
          phase_nxt = 1'b0;
        end
      end
      PWCD_H_GAP: begin
        if (tmr_done) begin
          wire_nxt = 1'b1;
          left_nxt = left_r - 1'b1;
          if (last_one) begin
            st_nxt  = PWCD_H_HOLD;
            tmr_nxt = HOLD - 1'b1;
          end else begin
            st_nxt  = PWCD_H_PULSE;
            tmr_nxt = PULSE - 1'b1;
          end
        end
      end
      PWCD_H_PULSE: begin
        if (tmr_done) begin
          st_nxt   = PWCD_H_GAP;
          wire_nxt = 1'b0;
          tmr_nxt  = PULSE - 1'b1;
        end
      end
      PWCD_H_HOLD: begin
        if (tmr_done) begin
          if (!phase_r) begin
            st_nxt    = PWCD_H_GAP;
            wire_nxt  = 1'b0;
            tmr_nxt   = PULSE - 1'b1;
            left_nxt  = {1'b0, data_r} + 1'b1;
            phase_nxt = 1'b1;
          end else begin
            st_nxt = PWCD_H_IDLE;
          end
        end
      end
      PWCD_H_SHUT: begin
        if (tmr_done) begin
          st_nxt = PWCD_H_OFF;
          on_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt   = PWCD_H_OFF;
        wire_nxt = 1'b0;
        on_nxt   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r    <= PWCD_H_OFF;
      tmr_r   <= '0;
      left_r  <= '0;
      data_r  <= '0;
      phase_r <= 1'b0;
      wire_r  <= 1'b0;
      on_r    <= 1'b0;
      rdy_r   <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      tmr_r   <= tmr_nxt;
      left_r  <= left_nxt;
      data_r  <= data_nxt;
      phase_r <= phase_nxt;
      wire_r  <= wire_nxt;
      on_r    <= on_nxt;
      rdy_r   <= (st_nxt == PWCD_H_IDLE) & ~shut_req;
    end
  end

  assign link.single_wire_control_pin = wire_r;
  assign cmd_ready = rdy_r;
  assign dev_on    = on_r;

endmodule

// *** bench/pwcd_props.sv ***
// Checker for the control wire and the device end's outputs.
// Assumes one clock and the timing parameters handed to the device.
module pwcd_props #(
  parameter logic [pwcd_pkg::RUN_W-1:0] WAKE    = pwcd_pkg::WAKE_CYC,
  parameter logic [pwcd_pkg::RUN_W-1:0] HOLD    = pwcd_pkg::HOLD_CYC,
  parameter logic [pwcd_pkg::RUN_W-1:0] STANDBY = pwcd_pkg::STANDBY_CYC,
  parameter logic [pwcd_pkg::RUN_W-1:0] BUS_RST = pwcd_pkg::BUS_RESET_CYC,
  parameter logic [pwcd_pkg::RUN_W-1:0] SHUTDN  = pwcd_pkg::SHUTDOWN_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic single_wire_control_pin,
  input wire logic sinks_off,
  input wire logic enabled,
  input wire logic sleep,
  input wire logic addr_valid,
  input wire logic wr_valid,
  input wire logic bus_reset_pulse,
  input wire logic standby
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Run lengths of the wire level
  // ==========================================================================
  logic [pwcd_pkg::RUN_W-1:0] hi_cnt_r;
  logic [pwcd_pkg::RUN_W-1:0] lo_cnt_r;
  logic [pwcd_pkg::RUN_W-1:0] run_r;

  // The last high run is kept through the following low gap.
  always_ff @(posedge clk) begin
    if (reset) begin
      hi_cnt_r <= '0;
      lo_cnt_r <= '0;
      run_r    <= '0;
    end else begin
      hi_cnt_r <= single_wire_control_pin ? hi_cnt_r + 1'b1 : '0;
      lo_cnt_r <= single_wire_control_pin ? '0 : lo_cnt_r + 1'b1;
      if (single_wire_control_pin) run_r <= hi_cnt_r + 1'b1;
    end
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  AST_WAKE_EARLY: assert property ($rose(enabled) |-> hi_cnt_r >= WAKE)
    else $error("device woke before the wake level was long enough");
  AST_WAKE_LATE: assert property (hi_cnt_r == WAKE + 3'h5 |-> enabled)
    else $error("device still off after a long wake level");
  AST_SHUT_EARLY: assert property ($fell(enabled) |-> lo_cnt_r >= SHUTDN)
    else $error("device shut down after too short a low level");
  AST_SHUT_LATE: assert property (lo_cnt_r == SHUTDN + 3'h6 |-> !enabled)
    else $error("device still on after a long low level");
  AST_ADDR_HOLD: assert property (addr_valid |-> run_r >= HOLD)
    else $error("address latched before the hold ended");
  AST_DATA_HOLD: assert property (wr_valid |-> single_wire_control_pin && run_r >= HOLD)
    else $error("data latched before the hold ended");
  AST_WR_ONCE: assert property (wr_valid |=> !wr_valid [*8])
    else $error("one data group gave more than one write");
  AST_STANDBY_LATE: assert property (enabled && hi_cnt_r == STANDBY + 3'h6 |-> standby)
    else $error("decoder not idle after a long high level");
  AST_BUS_RESET: assert property (bus_reset_pulse |-> hi_cnt_r >= BUS_RST)
    else $error("bus reset after too short a high level");
  AST_SLEEP: assert property (enabled && $past(sinks_off) |-> sleep)
    else $error("no sleep with all sinks off");
  AST_SLEEP_ON: assert property (sleep |-> enabled)
    else $error("sleep shown while the device is off");
  AST_OFF_QUIET: assert property (!enabled |-> !addr_valid && !wr_valid)
    else $error("latch while the device is off");
endmodule

// *** bench/testbench.sv ***
// Bench joining the host and device ends over the control wire.
// Assumes short timing parameters; inputs change on falling clk edges.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Short timing, signals and the two ends
  // ==========================================================================
  localparam logic [pwcd_pkg::RUN_W-1:0] WK = 21'h32;
  localparam logic [pwcd_pkg::RUN_W-1:0] PL = 21'h4;
  localparam logic [pwcd_pkg::RUN_W-1:0] HD = 21'h3c;
  localparam logic [pwcd_pkg::RUN_W-1:0] SB = 21'hc8;
  localparam logic [pwcd_pkg::RUN_W-1:0] BR = 21'hf0;
  localparam logic [pwcd_pkg::RUN_W-1:0] SD = 21'h64;
  localparam logic [15:0]                CMDS [4] = '{16'h0000, 16'hff01, 16'h01ff, 16'h2a55};

  logic       clk;
  logic       reset;
  logic       sinks_off;
  logic       wake_req;
  logic       shut_req;
  logic       cmd_valid;
  logic [7:0] cmd_addr;
  logic [7:0] cmd_data;
  logic       cmd_ready;
  logic       dev_on;
  logic       enabled;
  logic       sleep;
  logic       addr_valid;
  logic       wr_valid;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic       bus_reset_pulse;
  logic       standby;
  int         num_errors;
  int         total_checks;
  wire  [7:0] flags;

  assign flags = {dev_on, cmd_ready, standby, bus_reset_pulse, wr_valid, addr_valid, enabled,
                  sleep};

  pwcd_if pwcd_if_i ();

  pwcd_host #(.WAKE(WK), .PULSE(PL), .HOLD(HD), .SHUTDN(SD)) pwcd_host_i (
    .clk(clk), .reset(reset), .link(pwcd_if_i.host_end), .wake_req(wake_req),
    .shut_req(shut_req), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .dev_on(dev_on));

  pwcd_device #(.WAKE(WK), .HOLD(HD), .STANDBY(SB), .BUS_RST(BR), .SHUTDN(SD)) pwcd_device_i (
    .clk(clk), .reset(reset), .link(pwcd_if_i.device_end), .sinks_off(sinks_off),
    .enabled(enabled), .sleep(sleep), .addr_valid(addr_valid), .wr_valid(wr_valid),
    .wr_addr(wr_addr), .wr_data(wr_data), .bus_reset_pulse(bus_reset_pulse), .standby(standby));

  pwcd_props #(.WAKE(WK), .HOLD(HD), .STANDBY(SB), .BUS_RST(BR), .SHUTDN(SD)) pwcd_props_i (
    .clk(clk), .reset(reset), .single_wire_control_pin(pwcd_if_i.single_wire_control_pin),
    .sinks_off(sinks_off), .enabled(enabled), .sleep(sleep), .addr_valid(addr_valid),
    .wr_valid(wr_valid), .bus_reset_pulse(bus_reset_pulse), .standby(standby));

  always #5 clk = ~clk;

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic stop_test();
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits at falling edges until flag k shows v; running out ends the run.
  task automatic wait_for(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (flags[k] !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    check(flags[k], v);
    if (flags[k] !== v) stop_test();
  endtask

  task automatic send(input logic [7:0] a, input logic [7:0] d);
    wait_for(6, 1'b1, 200);
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    wait_for(2, 1'b1, 4000);
    check(wr_addr, a);
    wait_for(3, 1'b1, 4000);
    check(wr_addr, a);
    check(wr_data, d);
  endtask

  task automatic wake_up();
    wake_req = 1'b1;
    wait_for(1, 1'b1, 200);
    wait_for(7, 1'b1, 200);
    wake_req = 1'b0;
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    sinks_off = 1'b0;
    wake_req = 1'b0;
    shut_req = 1'b0;
    cmd_valid = 1'b0;
    cmd_addr = 8'h00;
    cmd_data = 8'h00;
    num_errors = 0;
    total_checks = 0;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    check(flags, 8'h00);
    wake_up();
    for (int i = 0; i < 4; i++) begin
      send(CMDS[i][15:8], CMDS[i][7:0]);
    end
    sinks_off = 1'b1;
    repeat (2) @(negedge clk);
    check(sleep, 1'b1);
    send(8'h07, 8'h5a);
    wait_for(5, 1'b1, 400);
    wait_for(4, 1'b1, 400);
    @(negedge clk);
    check(wr_addr, 8'h00);
    send(8'h03, 8'h81);
    shut_req = 1'b1;
    wait_for(1, 1'b0, 400);
    wait_for(7, 1'b0, 400);
    shut_req = 1'b0;
    @(negedge clk);
    check(sleep, 1'b0);
    wake_up();
    send(8'hfe, 8'h10);
    stop_test();
  end
endmodule
